// file: hdl/dsg_pkg.sv
// Constants, carriers and mode type of the deep-sleep clock gating bank
package dsg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int NUM_UNITS = 10;
    localparam int IRQ_W = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] RUN_CFG_OFF = 12'h060;
    localparam logic [ADDR_W-1:0] RUN_EN_OFF = 12'h104;
    localparam logic [ADDR_W-1:0] SLEEP_EN_OFF = 12'h114;
    localparam logic [ADDR_W-1:0] DEEP_EN_OFF = 12'h124;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 12'h200;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 12'h204;

    // Reset values and the set of bits with a unit behind them
    localparam logic [DATA_W-1:0] EN_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] EN_IMPL_MASK = 32'h0107_1037;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Field positions
    localparam int AUTO_GATE_BIT = 0;
    localparam int COMP_A_BIT = 24;
    localparam int TIMER_C_BIT = 18;
    localparam int TIMER_B_BIT = 17;
    localparam int TIMER_A_BIT = 16;
    localparam int TWO_WIRE_A_BIT = 12;
    localparam int SYNC_B_BIT = 5;
    localparam int SYNC_A_BIT = 4;
    localparam int ASYNC_C_BIT = 2;
    localparam int ASYNC_B_BIT = 1;
    localparam int ASYNC_A_BIT = 0;
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_UNMAPPED_BIT = 1;

    // Unit index to enable bit: async a,b,c, sync a,b, two-wire, timers a,b,c, comparator
    localparam int UNIT_POS [NUM_UNITS] = '{ASYNC_A_BIT, ASYNC_B_BIT, ASYNC_C_BIT, SYNC_A_BIT, SYNC_B_BIT,
                                            TWO_WIRE_A_BIT, TIMER_A_BIT, TIMER_B_BIT, TIMER_C_BIT, COMP_A_BIT};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } dsg_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } dsg_apb_rsp_t;

    typedef enum {MODE_RUN, MODE_SLEEP, MODE_DEEP} dsg_mode_t;
endpackage

// file: hdl/dsg_clk_gate.sv
// Glitch-free clock gate cell for one peripheral unit
`timescale 1ns/100ps
module dsg_clk_gate (
    input wire logic clk_i,
    input wire logic enable_i,
    output logic gclk_o
);
    logic en_latch;

    // Latch is open only while the clock is low, so the AND never sees a mid-pulse change
    always_latch begin
        if (!clk_i) begin
            en_latch <= enable_i;
        end
    end

    assign gclk_o = clk_i & en_latch;
endmodule

// file: hdl/dsg_clock_gating_bank.sv
// Deep-sleep clock gating bank: APB registers, mode selection, gated unit clocks and fault reporting
`timescale 1ns/100ps
module dsg_clock_gating_bank
    import dsg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input dsg_apb_req_t apb_req_i,
    output dsg_apb_rsp_t apb_rsp_o,
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic [NUM_UNITS-1:0] unit_access_i,
    output logic [NUM_UNITS-1:0] unit_fault_o,
    output logic [NUM_UNITS-1:0] unit_clk_en_o,
    output logic [NUM_UNITS-1:0] unit_clk_o,
    output logic irq_o
);
    logic [DATA_W-1:0] run_cfg_reg;
    logic [DATA_W-1:0] run_en_reg;
    logic [DATA_W-1:0] sleep_en_reg;
    logic [DATA_W-1:0] deep_en_reg;
    logic [DATA_W-1:0] active_en_next;
    logic [DATA_W-1:0] active_en_reg;
    logic [NUM_UNITS-1:0] unit_en_vec;
    logic [NUM_UNITS-1:0] unit_fault_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic irq_reg;
    dsg_mode_t mode_reg;
    dsg_mode_t mode_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic addr_hit;
    logic access_phase;
    logic xfer_done;
    logic wr_done;
    logic auto_gate;

    assign access_phase = apb_req_i.psel & apb_req_i.penable;
    // Writes land at the edge where the master sees pready high
    assign xfer_done = access_phase & pready_reg;
    assign wr_done = xfer_done & apb_req_i.pwrite & ~pslverr_reg;
    assign auto_gate = run_cfg_reg[AUTO_GATE_BIT];

    // Address decode and read mux
    always_comb begin
        addr_hit = 1'b1;
        rdata_next = '0;
        case (apb_req_i.paddr)
            RUN_CFG_OFF: rdata_next = run_cfg_reg;
            RUN_EN_OFF: rdata_next = run_en_reg;
            SLEEP_EN_OFF: rdata_next = sleep_en_reg;
            DEEP_EN_OFF: rdata_next = deep_en_reg;
            IRQ_STAT_OFF: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
            IRQ_MASK_OFF: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
            default: addr_hit = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= access_phase & ~pready_reg;
            pslverr_reg <= access_phase & ~pready_reg & ~addr_hit;
            prdata_reg <= (access_phase & ~pready_reg & ~apb_req_i.pwrite) ? rdata_next : '0;
        end
    end

    // Configuration register carrying the automatic sleep-gating select
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_cfg_reg <= CFG_RESET;
        end else if (wr_done && apb_req_i.paddr == RUN_CFG_OFF) begin
            run_cfg_reg <= apb_req_i.pwdata & (32'h0000_0001 << AUTO_GATE_BIT);
        end
    end

    // Three gating registers of one layout; unimplemented bits never store
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_en_reg <= EN_RESET;
            sleep_en_reg <= EN_RESET;
            deep_en_reg <= EN_RESET;
        end else if (wr_done) begin
            if (apb_req_i.paddr == RUN_EN_OFF) begin
                run_en_reg <= apb_req_i.pwdata & EN_IMPL_MASK;
            end
            if (apb_req_i.paddr == SLEEP_EN_OFF) begin
                sleep_en_reg <= apb_req_i.pwdata & EN_IMPL_MASK;
            end
            if (apb_req_i.paddr == DEEP_EN_OFF) begin
                deep_en_reg <= apb_req_i.pwdata & EN_IMPL_MASK;
            end
        end
    end

    // Power mode follows the request lines; deep sleep takes priority
    always_comb begin
        mode_next = MODE_RUN;
        case (mode_reg)
            MODE_RUN, MODE_SLEEP, MODE_DEEP: begin
                if (deep_sleep_req_i) begin
                    mode_next = MODE_DEEP;
                end else if (sleep_req_i) begin
                    mode_next = MODE_SLEEP;
                end
            end
            default: mode_next = MODE_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg <= MODE_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Sleep registers only count when automatic gating is selected
    always_comb begin
        active_en_next = run_en_reg;
        if (auto_gate) begin
            case (mode_reg)
                MODE_SLEEP: active_en_next = sleep_en_reg;
                MODE_DEEP: active_en_next = deep_en_reg;
                default: active_en_next = run_en_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_en_reg <= EN_RESET;
        end else begin
            active_en_reg <= active_en_next & EN_IMPL_MASK;
        end
    end

    // Per-unit enable pick, gated clock and fault flag
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        assign unit_en_vec[u] = active_en_reg[UNIT_POS[u]];

        dsg_clk_gate u_gate (
            .clk_i(clk_sys_i),
            .enable_i(unit_en_vec[u]),
            .gclk_o(unit_clk_o[u])
        );
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unit_fault_reg <= '0;
        end else begin
            unit_fault_reg <= unit_access_i & ~unit_en_vec;
        end
    end

    assign unit_fault_o = unit_fault_reg;
    assign unit_clk_en_o = unit_en_vec;

    // Sticky status: a new event in the clearing cycle survives the clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_done && apb_req_i.paddr == IRQ_STAT_OFF) begin
            irq_stat_next = irq_stat_reg & ~apb_req_i.pwdata[IRQ_W-1:0];
        end
        if (|(unit_access_i & ~unit_en_vec)) begin
            irq_stat_next[IRQ_FAULT_BIT] = 1'b1;
        end
        if (xfer_done && pslverr_reg) begin
            irq_stat_next[IRQ_UNMAPPED_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_reg <= IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_reg <= IRQ_RESET;
        end else if (wr_done && apb_req_i.paddr == IRQ_MASK_OFF) begin
            irq_mask_reg <= apb_req_i.pwdata[IRQ_W-1:0];
        end
    end

    // Interrupt built from next values so it stays coincident with the status register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_reg <= 1'b0;
        end else if (wr_done && apb_req_i.paddr == IRQ_MASK_OFF) begin
            irq_reg <= |(irq_stat_next & apb_req_i.pwdata[IRQ_W-1:0]);
        end else begin
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    assign irq_o = irq_reg;
    assign apb_rsp_o.prdata = prdata_reg;
    assign apb_rsp_o.pready = pready_reg;
    assign apb_rsp_o.pslverr = pslverr_reg;

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_setup;
        apb_req_i.psel && !apb_req_i.penable;
    endsequence

    sequence s_access_wait;
        access_phase && !pready_reg;
    endsequence

    a_apb_one_wait: assert property (s_setup ##1 s_access_wait |=> pready_reg)
        else $error("pready did not follow one wait cycle");

    a_deep_write_mask: assert property (wr_done && apb_req_i.paddr == DEEP_EN_OFF
        |=> deep_en_reg == ($past(apb_req_i.pwdata) & EN_IMPL_MASK))
        else $error("deep-sleep enables not stored as written");

    a_reserved_zero: assert property ((deep_en_reg & ~EN_IMPL_MASK) == '0
        && (active_en_reg & ~EN_IMPL_MASK) == '0)
        else $error("reserved enable bit became nonzero");

    // A write landing in the same cycle moves the source one edge ahead of the selection
    a_deep_select: assert property (auto_gate && mode_reg == MODE_DEEP
        && !(wr_done && apb_req_i.paddr == DEEP_EN_OFF) |=> active_en_reg == deep_en_reg)
        else $error("deep-sleep enables not applied");

    a_run_fallback: assert property (!auto_gate && !(wr_done && apb_req_i.paddr == RUN_EN_OFF)
        |=> active_en_reg == run_en_reg)
        else $error("run enables not applied without auto gating");

    a_sleep_select: assert property (auto_gate && mode_reg == MODE_SLEEP
        && !(wr_done && apb_req_i.paddr == SLEEP_EN_OFF) |=> active_en_reg == sleep_en_reg)
        else $error("sleep enables not applied");

    a_run_auto: assert property (auto_gate && mode_reg == MODE_RUN
        && !(wr_done && apb_req_i.paddr == RUN_EN_OFF) |=> active_en_reg == run_en_reg)
        else $error("run enables not applied in run mode");

    a_deep_priority: assert property (deep_sleep_req_i |=> mode_reg == MODE_DEEP)
        else $error("deep-sleep request not taken");

    a_timer_b_gate: assert property (unit_en_vec[7] == active_en_reg[TIMER_B_BIT])
        else $error("timer b clock enable not from bit 17");

    a_fault_gated: assert property (unit_access_i[0] && !unit_en_vec[0] |=> unit_fault_o[0]
        ##0 irq_stat_reg[IRQ_FAULT_BIT])
        else $error("access to gated unit gave no fault");

    a_no_fault_open: assert property (unit_en_vec[9] |=> !unit_fault_o[9])
        else $error("fault raised on clocked unit");

    a_unmapped_err: assert property (s_access_wait ##0 !addr_hit |=> pready_reg && pslverr_reg)
        else $error("unmapped address not answered with error");

    a_irq_level: assert property (irq_o == |(irq_stat_reg & irq_mask_reg))
        else $error("interrupt level disagrees with status and mask");

    a_status_sticky: assert property (irq_stat_reg[IRQ_FAULT_BIT] && !(wr_done && apb_req_i.paddr == IRQ_STAT_OFF)
        |=> irq_stat_reg[IRQ_FAULT_BIT])
        else $error("fault status lost without clear");

    sequence s_fault_clear;
        wr_done && apb_req_i.paddr == IRQ_STAT_OFF && apb_req_i.pwdata[IRQ_FAULT_BIT];
    endsequence

    a_status_clear: assert property (s_fault_clear ##0 !(|(unit_access_i & ~unit_en_vec))
        |=> !irq_stat_reg[IRQ_FAULT_BIT])
        else $error("fault status not cleared by writing one");

    sequence s_ready_pulse;
        pready_reg ##1 !pready_reg;
    endsequence

    a_ready_single: assert property (pready_reg |-> s_ready_pulse)
        else $error("pready held longer than one cycle");

    a_err_needs_ready: assert property (pslverr_reg |-> pready_reg)
        else $error("pslverr raised without pready");
endmodule

// file: tb/dsg_unit_model.sv
// Peripheral units behind the gated clocks: each counts the clock edges it receives
`timescale 1ns/100ps
module dsg_unit_model
    import dsg_pkg::*;
(
    input wire logic [NUM_UNITS-1:0] unit_clk_i,
    output logic [NUM_UNITS-1:0][7:0] edge_cnt_o
);
    // Counters wrap; the bench only ever looks at short differences
    for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
        logic [7:0] cnt = 8'h00;
        always @(posedge unit_clk_i[g]) begin
            cnt <= cnt + 8'h01;
        end
        assign edge_cnt_o[g] = cnt;
    end
endmodule

// file: tb/dsg_clock_gating_bank_test.sv
// Self-checking testbench of the deep-sleep clock gating bank
`timescale 1ns/100ps
module dsg_clock_gating_bank_test;
    import dsg_pkg::*;
    localparam logic [ADDR_W-1:0] OFFS [6] = '{RUN_CFG_OFF, RUN_EN_OFF, SLEEP_EN_OFF, DEEP_EN_OFF,
                                               IRQ_STAT_OFF, IRQ_MASK_OFF};
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    dsg_apb_req_t req = '0;
    dsg_apb_rsp_t rsp;
    logic sleep_req = 1'b0;
    logic deep_req = 1'b0;
    logic [NUM_UNITS-1:0] acc = '0;
    logic [NUM_UNITS-1:0] fault, clk_en, uclk;
    logic irq;
    logic [NUM_UNITS-1:0][7:0] cnt, c0;
    logic [DATA_W-1:0] rd;
    logic er;
    int n_errors = 0;
    int n_tests = 0;

    dsg_clock_gating_bank i_dsg_clock_gating_bank (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .sleep_req_i(sleep_req), .deep_sleep_req_i(deep_req),
        .unit_access_i(acc), .unit_fault_o(fault), .unit_clk_en_o(clk_en), .unit_clk_o(uclk), .irq_o(irq));
    dsg_unit_model i_dsg_unit_model (.unit_clk_i(uclk), .edge_cnt_o(cnt));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        // Wait for the slave without assuming its wait states; only the watchdog ends a hang
        do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, '0);
        chk(rd, exp);
        chk(er, 1'b0);
    endtask

    // Mode and enable changes settle within three edges
    task automatic gate_chk(input logic [NUM_UNITS-1:0] exp);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(clk_en, exp);
        chk(uclk, exp);
        c0 = cnt;
        repeat (8) @(posedge clk_sys_i);
        #1;
        for (int i = 0; i < NUM_UNITS; i++) chk(8'(cnt[i] - c0[i]), exp[i] ? 8'h08 : 8'h00);
        @(negedge clk_sys_i);
        #1;
        chk(uclk, '0);
    endtask

    task automatic strobe(input logic [NUM_UNITS-1:0] s, input logic [NUM_UNITS-1:0] f, input logic q);
        @(posedge clk_sys_i);
        acc <= s;
        @(posedge clk_sys_i);
        acc <= '0;
        #1;
        chk(fault, f);
        chk(irq, q);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 6; i++) rdc(OFFS[i], 32'h0000_0000);
        gate_chk('0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        for (int i = 1; i < 4; i++) begin
            wr(OFFS[i], 32'hffff_ffff);
            rdc(OFFS[i], EN_IMPL_MASK);
            wr(OFFS[i], 32'h0000_0000);
        end
        apb(1'b1, 12'h3f0, 32'hffff_ffff);
        chk(er, 1'b1);
        apb(1'b0, 12'h3f0, '0);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b1);
        rdc(IRQ_STAT_OFF, 32'h0000_0002);
        wr(IRQ_MASK_OFF, 32'h0000_0002);
        #1;
        chk(irq, 1'b1);
        wr(IRQ_STAT_OFF, 32'h0000_0002);
        #1;
        chk(irq, 1'b0);
        wr(IRQ_MASK_OFF, 32'h0000_0000);
        rdc(IRQ_STAT_OFF, 32'h0000_0000);
        $display("test registers done");
    endtask

    task automatic t_walk();
        for (int i = 0; i < NUM_UNITS; i++) begin
            wr(RUN_EN_OFF, 32'h1 << UNIT_POS[i]);
            gate_chk(10'(1 << i));
        end
        wr(RUN_EN_OFF, ~EN_IMPL_MASK);
        gate_chk('0);
        $display("test walk done");
    endtask

    task automatic t_modes();
        wr(RUN_EN_OFF, EN_IMPL_MASK);
        wr(SLEEP_EN_OFF, 32'h1 << SYNC_B_BIT);
        wr(DEEP_EN_OFF, 32'h1 << TIMER_B_BIT);
        @(posedge clk_sys_i);
        deep_req <= 1'b1;
        gate_chk('1);
        wr(RUN_CFG_OFF, 32'hffff_ffff);
        rdc(RUN_CFG_OFF, 32'h0000_0001);
        gate_chk(10'h080);
        @(posedge clk_sys_i);
        deep_req <= 1'b0;
        sleep_req <= 1'b1;
        gate_chk(10'h010);
        @(posedge clk_sys_i);
        sleep_req <= 1'b0;
        gate_chk('1);
        wr(RUN_CFG_OFF, 32'h0000_0000);
        $display("test modes done");
    endtask

    task automatic t_fault();
        wr(RUN_EN_OFF, 32'h1 << TWO_WIRE_A_BIT);
        wr(IRQ_MASK_OFF, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        strobe(10'h020, 10'h000, 1'b0);
        strobe(10'h028, 10'h008, 1'b1);
        rdc(IRQ_STAT_OFF, 32'h0000_0001);
        wr(IRQ_STAT_OFF, 32'h0000_0001);
        rdc(IRQ_STAT_OFF, 32'h0000_0000);
        #1;
        chk(irq, 1'b0);
        wr(IRQ_MASK_OFF, 32'h0000_0000);
        strobe(10'h201, 10'h201, 1'b0);
        rdc(IRQ_STAT_OFF, 32'h0000_0001);
        $display("test fault done");
    endtask

    task automatic t_rerun();
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(irq, 1'b0);
        chk(fault, '0);
        chk(clk_en, '0);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        $display("test mid-run reset done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_walk();
        t_modes();
        t_fault();
        t_rerun();
        final_report();
    end
endmodule
